// file: hdl/apo_pkg.sv
// Constants shared by the parallel sample output block and its helpers.
// Assumes a 50 MHz system clock and a free-running conversion clock port.
package apo_pkg;

    // Width of each input level and of the signed difference between them
    localparam int IN_W = 16;
    localparam int DIFF_W = 17;

    // Output word layout: bit 0 is the LSB, bit 14 the sign bit
    localparam int WORD_W = 15;
    localparam int WORD_LSB = 0;
    localparam int WORD_MSB = 14;

    // Cycles from the sampling edge to the edge that updates the output
    localparam int LATENCY = 3;

    // Flip-flops in every synchroniser
    localparam int SYNC_STAGES = 2;

    // Full-scale limits of the difference, as signed values
    localparam logic signed [16:0] DIFF_POS_FS = 17'sh03FFF;
    localparam logic signed [16:0] DIFF_NEG_FS = 17'sh1C000;

    // Output codes at the limits and at midscale
    localparam logic [14:0] CODE_POS_FS = 15'h3FFF;
    localparam logic [14:0] CODE_NEG_FS = 15'h4000;
    localparam logic [14:0] CODE_MID = 15'h0000;

    // Reset values
    localparam logic [16:0] DIFF_RST = 17'h00000;
    localparam logic [14:0] WORD_RST = 15'h0000;

    // Source side of the word crossing
    typedef enum logic [1:0] {
        APO_SRC_IDLE = 2'b01,
        APO_SRC_BUSY = 2'b10
    } apo_src_state_t;

endpackage

// file: hdl/apo_rst_sync.sv
// Reset synchroniser for the conversion clock domain.
// Assumes the clock runs while reset is released; assertion is asynchronous.
`timescale 1ns/1ps
module apo_rst_sync (
    input wire logic clk, // Destination clock
    input wire logic rst_in_b, // Asynchronous reset, active low
    output logic rst_out_b // Reset with synchronous release
);

    logic [apo_pkg::SYNC_STAGES-1:0] chain;
    logic [apo_pkg::SYNC_STAGES-1:0] next_chain;

    // Shift ones in after release
    always_comb begin
        next_chain = {chain[apo_pkg::SYNC_STAGES-2:0], 1'b1};
    end

    // Clear at once on assertion so no stale state survives
    always_ff @(posedge clk or negedge rst_in_b) begin
        if (!rst_in_b) begin
            chain <= '0;
        end else begin
            chain <= next_chain;
        end
    end

    assign rst_out_b = chain[apo_pkg::SYNC_STAGES-1];

endmodule

// file: hdl/apo_word_cdc.sv
// Toggle handshake that carries one word from a source to a destination clock.
// Assumes the source word is sampled only when the previous transfer is acknowledged.
`timescale 1ns/1ps
module apo_word_cdc (
    input wire logic clk_src, // Source clock
    input wire logic rst_src_b, // Source reset, active low
    input wire logic [16:0] src_word, // Word to carry
    input wire logic clk_dst, // Destination clock
    input wire logic rst_dst_b, // Destination reset, active low
    output logic [16:0] dst_word, // Last word received
    output logic dst_new // Pulse when dst_word updates
);

    apo_pkg::apo_src_state_t state;
    apo_pkg::apo_src_state_t next_state;
    logic [16:0] hold;
    logic [16:0] next_hold;
    logic req_tog;
    logic next_req_tog;
    logic ack_meta;
    logic ack_sync;
    logic req_meta;
    logic req_sync;
    logic req_last;
    logic [16:0] next_dst_word;
    logic next_dst_new;

    // Load a word and toggle the request; wait until the acknowledge matches
    always_comb begin
        next_state = state;
        next_hold = hold;
        next_req_tog = req_tog;
        unique case (state)
            apo_pkg::APO_SRC_IDLE: begin
                next_hold = src_word;
                next_req_tog = ~req_tog;
                next_state = apo_pkg::APO_SRC_BUSY;
            end
            apo_pkg::APO_SRC_BUSY: begin
                if (ack_sync == req_tog) begin
                    next_state = apo_pkg::APO_SRC_IDLE;
                end
            end
        endcase
    end

    // Hold stays still while busy, so the destination reads a settled word
    always_ff @(posedge clk_src or negedge rst_src_b) begin
        if (!rst_src_b) begin
            state <= apo_pkg::APO_SRC_IDLE;
            hold <= apo_pkg::DIFF_RST;
            req_tog <= 1'b0;
            ack_meta <= 1'b0;
            ack_sync <= 1'b0;
        end else begin
            state <= next_state;
            hold <= next_hold;
            req_tog <= next_req_tog;
            ack_meta <= req_last;
            ack_sync <= ack_meta;
        end
    end

    // Capture on a request edge; req_last doubles as the acknowledge
    always_comb begin
        next_dst_word = (req_sync != req_last) ? hold : dst_word;
        next_dst_new = (req_sync != req_last);
    end

    always_ff @(posedge clk_dst or negedge rst_dst_b) begin
        if (!rst_dst_b) begin
            req_meta <= 1'b0;
            req_sync <= 1'b0;
            req_last <= 1'b0;
            dst_word <= apo_pkg::DIFF_RST;
            dst_new <= 1'b0;
        end else begin
            req_meta <= req_tog;
            req_sync <= req_meta;
            req_last <= req_sync;
            dst_word <= next_dst_word;
            dst_new <= next_dst_new;
        end
    end

endmodule

// file: hdl/apo_adc_out.sv
// Parallel sample output of a pipelined converter: input levels, sampling,
// pipeline, two's-complement coding, overrange flag and data-valid strobe.
// Assumes the input levels come from logic on clk_sys and that the
// conversion clock runs free with a duty cycle near one half.
`timescale 1ns/1ps
module apo_adc_out (
    input wire logic clk_sys, // System clock, 50 MHz
    input wire logic rst_b, // Asynchronous reset, active low
    input wire logic [15:0] analog_in_pos, // Positive input level
    input wire logic [15:0] analog_in_neg, // Negative input level
    input wire logic conv_clock_pos, // Conversion clock, true phase
    input wire logic conv_clock_neg, // Conversion clock, complement
    output logic [14:0] sample_word, // Two's-complement sample
    output logic overrange_flag, // High for an overrange sample
    output logic sample_valid_strobe // Rises when the word is valid
);

    // System domain state
    logic signed [16:0] diff;
    logic signed [16:0] next_diff;

    // Conversion domain state
    logic rst_conv_b;
    logic [16:0] xfer_word;
    logic xfer_new;
    logic signed [16:0] held;
    logic signed [16:0] next_held;
    logic have_sample;
    logic next_have_sample;
    logic [14:0] take_code;
    logic take_over;
    logic [14:0] pipe_word [apo_pkg::LATENCY];
    logic [14:0] next_pipe_word [apo_pkg::LATENCY];
    logic pipe_over [apo_pkg::LATENCY];
    logic next_pipe_over [apo_pkg::LATENCY];
    logic pipe_vld [apo_pkg::LATENCY];
    logic next_pipe_vld [apo_pkg::LATENCY];
    logic [14:0] next_sample_word;
    logic next_overrange_flag;
    logic out_vld;
    logic next_out_vld;
    logic phase_rise;
    logic next_phase_rise;
    logic phase_fall;
    logic next_phase_fall;

    // Differential level; widened by one bit so no pair can wrap
    always_comb begin
        next_diff = $signed({1'b0, analog_in_pos}) - $signed({1'b0, analog_in_neg});
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            diff <= apo_pkg::DIFF_RST;
        end else begin
            diff <= next_diff;
        end
    end

    // Reset release into the conversion domain; needs running conversion clock
    apo_rst_sync u_rst_sync (
        .clk(conv_clock_pos),
        .rst_in_b(rst_b),
        .rst_out_b(rst_conv_b)
    );

    // Handshake crossing; the newest settled level wins, older ones are dropped
    apo_word_cdc u_word_cdc (
        .clk_src(clk_sys),
        .rst_src_b(rst_b),
        .src_word(diff),
        .clk_dst(conv_clock_pos),
        .rst_dst_b(rst_conv_b),
        .dst_word(xfer_word),
        .dst_new(xfer_new)
    );

    // Track-and-hold: keep the latest level that crossed over
    always_comb begin
        next_held = xfer_new ? $signed(xfer_word) : held;
        next_have_sample = have_sample | xfer_new;
    end

    always_ff @(posedge conv_clock_pos or negedge rst_conv_b) begin
        if (!rst_conv_b) begin
            held <= apo_pkg::DIFF_RST;
            have_sample <= 1'b0;
        end else begin
            held <= next_held;
            have_sample <= next_have_sample;
        end
    end

    // Coding and range check of the level seen at the sampling edge
    always_comb begin
        if (held > apo_pkg::DIFF_POS_FS) begin
            take_code = apo_pkg::CODE_POS_FS;
            take_over = 1'b1;
        end else if (held < apo_pkg::DIFF_NEG_FS) begin
            take_code = apo_pkg::CODE_NEG_FS;
            take_over = 1'b1;
        end else begin
            // In range: low 15 bits are already two's complement
            take_code = held[apo_pkg::WORD_MSB:apo_pkg::WORD_LSB];
            take_over = 1'b0;
        end
    end

    // Pipeline; stage 0 loads at the sampling edge, output at the third edge
    always_comb begin
        next_pipe_word[0] = take_code;
        next_pipe_over[0] = take_over;
        next_pipe_vld[0] = have_sample;
    end

    for (genvar s = 1; s < apo_pkg::LATENCY; s++) begin : g_pipe
        always_comb begin
            next_pipe_word[s] = pipe_word[s-1];
            next_pipe_over[s] = pipe_over[s-1];
            next_pipe_vld[s] = pipe_vld[s-1];
        end
    end

    for (genvar s = 0; s < apo_pkg::LATENCY; s++) begin : g_pipe_reg
        always_ff @(posedge conv_clock_pos or negedge rst_conv_b) begin
            if (!rst_conv_b) begin
                pipe_word[s] <= apo_pkg::WORD_RST;
                pipe_over[s] <= 1'b0;
                pipe_vld[s] <= 1'b0;
            end else begin
                pipe_word[s] <= next_pipe_word[s];
                pipe_over[s] <= next_pipe_over[s];
                pipe_vld[s] <= next_pipe_vld[s];
            end
        end
    end

    // Output stage: word and flag move together, only on rising edges
    always_comb begin
        next_sample_word = pipe_word[apo_pkg::LATENCY-1];
        next_overrange_flag = pipe_over[apo_pkg::LATENCY-1];
        next_out_vld = pipe_vld[apo_pkg::LATENCY-1];
    end

    always_ff @(posedge conv_clock_pos or negedge rst_conv_b) begin
        if (!rst_conv_b) begin
            sample_word <= apo_pkg::CODE_MID;
            overrange_flag <= 1'b0;
            out_vld <= 1'b0;
        end else begin
            sample_word <= next_sample_word;
            overrange_flag <= next_overrange_flag;
            out_vld <= next_out_vld;
        end
    end

    // Strobe phase pair: the falling-edge flop opens the strobe,
    // the rising-edge flop closes it as the word changes
    always_comb begin
        next_phase_fall = out_vld ? ~phase_rise : phase_rise;
        next_phase_rise = phase_fall;
    end

    always_ff @(negedge conv_clock_pos or negedge rst_conv_b) begin
        if (!rst_conv_b) begin
            phase_fall <= 1'b0;
        end else begin
            phase_fall <= next_phase_fall;
        end
    end

    always_ff @(posedge conv_clock_pos or negedge rst_conv_b) begin
        if (!rst_conv_b) begin
            phase_rise <= 1'b0;
        end else begin
            phase_rise <= next_phase_rise;
        end
    end

    // Two flops, no clock gating, so the strobe cannot glitch;
    // half a cycle of setup before its rise, data holds to its fall
    assign sample_valid_strobe = phase_rise ^ phase_fall;

endmodule

// file: bench/apo_adc_out_chk.sv
// Checker for the parallel sample output: strobe phase, word timing, coding.
// Assumes binding to apo_adc_out and a free-running conversion clock.
`timescale 1ns/1ps
module apo_adc_out_chk (
    input wire logic clk_sys, // System clock
    input wire logic rst_b, // Reset, active low
    input wire logic [15:0] analog_in_pos, // Positive level
    input wire logic [15:0] analog_in_neg, // Negative level
    input wire logic conv_clock_pos, // Conversion clock
    input wire logic conv_clock_neg, // Complement, unused
    input wire logic [14:0] sample_word, // Output word
    input wire logic overrange_flag, // Overrange flag
    input wire logic sample_valid_strobe // Valid strobe
);
    logic signed [16:0] diff;
    logic [14:0] exp_word;
    logic exp_flag;
    logic [31:0] last_in;
    logic [3:0] age;
    logic [3:0] next_age;
    logic seen;
    // Expected code of the present levels, saturating at both limits
    always_comb begin
        diff = $signed({1'b0, analog_in_pos}) - $signed({1'b0, analog_in_neg});
        exp_flag = (diff > apo_pkg::DIFF_POS_FS) || (diff < apo_pkg::DIFF_NEG_FS);
        exp_word = diff[14:0];
        if (diff > apo_pkg::DIFF_POS_FS) exp_word = 15'h3FFF;
        if (diff < apo_pkg::DIFF_NEG_FS) exp_word = 15'h4000;
    end
    // Conversion edges since the levels last moved; saturates at 15
    always_comb begin
        next_age = (age == 4'hF) ? age : age + 4'h1;
        if ({analog_in_pos, analog_in_neg} != last_in) next_age = 4'h0;
    end
    always_ff @(posedge conv_clock_pos or negedge rst_b) begin
        if (!rst_b) begin
            age <= 4'h0;
            last_in <= 32'h00000000;
        end else begin
            age <= next_age;
            last_in <= {analog_in_pos, analog_in_neg};
        end
    end
    // Strobe has run once; the stream must not pause after that
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) seen <= 1'b0;
        else seen <= seen | sample_valid_strobe;
    end
    AST_WORD_AFTER_RISE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $changed(sample_word) |-> conv_clock_pos) else $error("word moved in low clock phase");
    AST_STROBE_DATA_STABLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $rose(sample_valid_strobe) |-> !conv_clock_pos && $stable(sample_word) && $stable(overrange_flag))
        else $error("data moving at strobe rise");
    AST_STROBE_LOW_PHASE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        sample_valid_strobe |-> !conv_clock_pos) else $error("strobe high in high clock phase");
    AST_STROBE_EVERY_CYCLE: assert property (@(posedge clk_sys) disable iff (!rst_b)
        seen && $fell(conv_clock_pos) |-> sample_valid_strobe) else $error("strobe missed a cycle");
    AST_WORD_CODE: assert property (@(posedge conv_clock_pos) disable iff (!rst_b)
        age == 4'hF && {analog_in_pos, analog_in_neg} == last_in |-> sample_word == exp_word)
        else $error("word code wrong");
    AST_FLAG_CODE: assert property (@(posedge conv_clock_pos) disable iff (!rst_b)
        age == 4'hF && {analog_in_pos, analog_in_neg} == last_in |-> overrange_flag == exp_flag)
        else $error("flag wrong");
    AST_FLAG_TIMING: assert property (@(posedge clk_sys) disable iff (!rst_b)
        $changed(overrange_flag) |-> conv_clock_pos) else $error("flag moved off word timing");
    // Crossing, hold, three stages and the output register give at least eight edges; a short pipeline shows as age below 7
    AST_LATENCY_MIN: assert property (@(posedge conv_clock_pos) disable iff (!rst_b)
        sample_word != $past(sample_word) |-> age >= 4'h7) else $error("word arrived too early");
    COV_STROBE: cover property (@(posedge clk_sys) $rose(sample_valid_strobe));
    COV_OVER: cover property (@(posedge conv_clock_pos) overrange_flag);
    COV_NEG_FS: cover property (@(posedge conv_clock_pos) sample_word == apo_pkg::CODE_NEG_FS);
endmodule

bind apo_adc_out apo_adc_out_chk u_apo_adc_out_chk (.clk_sys(clk_sys), .rst_b(rst_b),
    .analog_in_pos(analog_in_pos), .analog_in_neg(analog_in_neg), .conv_clock_pos(conv_clock_pos),
    .conv_clock_neg(conv_clock_neg), .sample_word(sample_word), .overrange_flag(overrange_flag),
    .sample_valid_strobe(sample_valid_strobe));

// file: bench/apo_capture.sv
// Downstream capture latch: registers word and flag on the valid strobe.
// Assumes the strobe is its only clock; it has no reset.
`timescale 1ns/1ps
module apo_capture (
    input wire logic sample_valid_strobe, // Capture clock
    input wire logic [14:0] sample_word, // Word from the converter
    input wire logic overrange_flag, // Flag from the converter
    output logic [15:0] rec, // Flag above word
    output logic [15:0] rec_count // Records taken, wraps
);
    initial begin
        rec = 16'h0000;
        rec_count = 16'h0000;
    end
    // Both parts on one edge, so a record never mixes two samples
    always @(posedge sample_valid_strobe) begin
        rec <= {overrange_flag, sample_word};
        rec_count <= rec_count + 16'h0001;
    end
endmodule

// file: bench/apo_adc_out_tb_top.sv
// Testbench for apo_adc_out: all code regions, strobe rate, reset mid-run.
// Assumes apo_capture as the far side and the bound checker.
`timescale 1ns/1ps
module apo_adc_out_tb_top;
    logic clk_sys;
    logic rst_b;
    logic conv_clock_pos;
    logic [15:0] analog_in_pos;
    logic [15:0] analog_in_neg;
    logic [14:0] sample_word;
    logic overrange_flag;
    logic sample_valid_strobe;
    logic [15:0] rec;
    logic [15:0] rec_count;
    int num_errors;
    int check_count;
    // System clock, 50 MHz
    initial begin
        clk_sys = 1'b0;
        forever #10 clk_sys = ~clk_sys;
    end
    // Conversion clock, 80 ns, even duty; offset keeps its edges off clk_sys
    initial begin
        conv_clock_pos = 1'b0;
        #7;
        forever #40 conv_clock_pos = ~conv_clock_pos;
    end
    apo_adc_out u_apo_adc_out (.clk_sys(clk_sys), .rst_b(rst_b), .analog_in_pos(analog_in_pos),
        .analog_in_neg(analog_in_neg), .conv_clock_pos(conv_clock_pos), .conv_clock_neg(~conv_clock_pos),
        .sample_word(sample_word), .overrange_flag(overrange_flag), .sample_valid_strobe(sample_valid_strobe));
    apo_capture u_apo_capture (.sample_valid_strobe(sample_valid_strobe), .sample_word(sample_word),
        .overrange_flag(overrange_flag), .rec(rec), .rec_count(rec_count));
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        check_count++;
        if (seen !== exp) begin
            num_errors++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic finish_test;
        $display("checks %0d mismatches %0d", check_count, num_errors);
        if (num_errors == 0 && check_count > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    // Set both levels, then wait a bounded time for the matching record
    task automatic apply(input logic [15:0] pos, input logic [15:0] neg, input logic [15:0] exp);
        int i;
        @(posedge clk_sys);
        analog_in_pos <= pos;
        analog_in_neg <= neg;
        for (i = 0; i < 200 && rec !== exp; i++) @(posedge clk_sys);
        check(rec, exp);
        if (rec !== exp) finish_test();
    endtask
    // Each code region and both limits; eight records per 640 ns window
    task automatic test_codes;
        logic [47:0] tbl [9];
        logic [15:0] n0;
        tbl = '{48'h3FFF_0000_3FFF, 48'h4000_0000_BFFF, 48'h0000_4000_4000, 48'h0000_4001_C000,
            48'hFFFF_0000_BFFF, 48'h0000_FFFF_C000, 48'h1234_1234_0000, 48'h0000_0001_7FFF,
            48'h0001_0000_0001};
        for (int k = 0; k < 9; k++) begin
            apply(tbl[k][47:32], tbl[k][31:16], tbl[k][15:0]);
            n0 = rec_count;
            repeat (32) @(posedge clk_sys);
            check(rec_count - n0, 16'h0008);
            check(rec, tbl[k][15:0]);
        end
        $display("test_codes done");
    endtask
    // Reset mid-run: outputs clear, strobe stops, then the stream resumes
    task automatic test_reset;
        @(posedge clk_sys);
        rst_b <= 1'b0;
        repeat (16) @(posedge clk_sys);
        check({overrange_flag, sample_word}, 16'h0000);
        check({15'h0000, sample_valid_strobe}, 16'h0000);
        rst_b <= 1'b1;
        apply(16'h0000, 16'h0010, 16'h7FF0);
        $display("test_reset done");
    endtask
    initial begin
        num_errors = 0;
        check_count = 0;
        rst_b = 1'b0;
        analog_in_pos = 16'h0000;
        analog_in_neg = 16'h0000;
        repeat (16) @(posedge clk_sys);
        rst_b <= 1'b1;
        test_codes();
        test_reset();
        finish_test();
    end
endmodule
